/* pkg/spi_port_pkg.sv */
// constants, field layouts and carrier types of the serial port
package spi_port_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [15:0] PORT_OFFSET = 16'h1008;
    localparam logic [15:0] DIR_OFFSET = 16'h1009;
    localparam logic [15:0] CTRL_OFFSET = 16'h1028;
    localparam logic [15:0] FLAGS_OFFSET = 16'h1029;
    localparam logic [15:0] DATA_OFFSET = 16'h102a;

    // ************************************************************
    // reset values and field positions
    // ************************************************************
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] PORT_RESET = 8'h00;
    localparam int TC_BIT = 7;
    localparam int WRITE_COLLISION_FLAG_BIT = 6;
    localparam int MODE_FAULT_FLAG_BIT = 4;
    localparam int MISO_PIN = 2;
    localparam int MOSI_PIN = 3;
    localparam int SCK_PIN = 4;
    localparam int SS_PIN = 5;

    // ************************************************************
    // timing counts, in bus clock cycles per half serial clock, and last half and sample indices
    // ************************************************************
    localparam logic [4:0] HALF_DIV2 = 5'h01;
    localparam logic [4:0] HALF_DIV4 = 5'h02;
    localparam logic [4:0] HALF_DIV16 = 5'h08;
    localparam logic [4:0] HALF_DIV32 = 5'h10;
    localparam logic [4:0] LAST_HALF = 5'h0f;
    localparam logic [3:0] LAST_SAMPLE = 4'h7;

    // ************************************************************
    // carrier types
    // ************************************************************
    typedef struct packed {
        logic int_en;
        logic sys_en;
        logic open_drain;
        logic master;
        logic cpol;
        logic cpha;
        logic [1:0] rate;
    } ctrl_t;

    // port d pins 5..2
    typedef struct packed {
        logic ss;
        logic sck;
        logic mosi;
        logic miso;
    } pins_t;

    typedef enum logic [1:0] {
        XFER_IDLE = 2'b00,
        XFER_RUN = 2'b01,
        XFER_HOLD = 2'b11
    } xfer_state_t;

endpackage : spi_port_pkg

/* rtl/sync_stage.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync_stage #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            meta_reg <= '1;
            sync_out <= '1;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : sync_stage
`default_nettype wire

/* rtl/spi_master_slave_port.sv */
// serial peripheral port, master or slave, with register file
// Function
// - master sees select low, sets mode fault
// - select pin direction bit masks mode fault
// - phase zero shift clock is select OR clock
// - phase one select may stay low between bytes
// - mode fault drops master bit, pin directions
// - busy data write flags collision, is dropped
// - master starts on data write, ends flagged
// - slave phase zero spans select low period
// - slave phase one starts at first active edge
// - interrupt from complete, mode fault flags, gated by enable, mask
// - enable hands pins 2..4 to port, pin 5 too unless master with select output
// - open drain bit switches all port drives
// - master clock rests at polarity level
// - rate field divides by 2,4,16,32 as master
// - complete flag clears by flags read, data access
// - collision flag clears by flags read, data access
// - mode fault clears by flags read, control write
// - receive buffer separate, overrun keeps old byte
// - only master write starts; both flag completion
// - one byte each way over eight clocks
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [7:0] bus_rdata,
    input wire logic cpu_int_mask,
    output logic irq_request,
    input wire spi_port_pkg::pins_t pin_in,
    output spi_port_pkg::pins_t pin_out,
    output spi_port_pkg::pins_t pin_oe
);
    import spi_port_pkg::*;

    // ************************************************************
    // declarations
    // ************************************************************
    pins_t pin_sync;
    ctrl_t ctrl_reg;
    xfer_state_t state_reg;
    pins_t drv_c;
    pins_t val_c;
    logic [7:0] dir_reg, port_reg, shreg, rx_buf, rx_value;
    logic [4:0] div_cnt, half_idx, half_len;
    logic [3:0] samp_cnt;
    logic tc_reg, write_collision_flag_reg, mode_fault_flag_reg, tc_armed, write_collision_flag_armed, mode_fault_flag_armed;
    logic msck_reg, out_bit, clk_prev, ss_prev;
    logic wr_data, rd_data, wr_ctrl, rd_flags, wr_dir, wr_port, data_acc;
    logic en, is_master, act_lvl, shift_clk, rise, fall, ss_fall, ss_rise;
    logic tick, sample_ev, drive_ev, xfer_done, busy, load_ok, abort;
    logic mode_fault_flag_set, tc_set, tc_clr, din;

    sync_stage #(.WIDTH(4)) u_sync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // ************************************************************
    // register decode
    // ************************************************************
    assign wr_data = bus_write && (bus_addr == DATA_OFFSET);
    assign rd_data = bus_read && (bus_addr == DATA_OFFSET);
    assign wr_ctrl = bus_write && (bus_addr == CTRL_OFFSET);
    assign rd_flags = bus_read && (bus_addr == FLAGS_OFFSET);
    assign wr_dir = bus_write && (bus_addr == DIR_OFFSET);
    assign wr_port = bus_write && (bus_addr == PORT_OFFSET);
    assign data_acc = wr_data || rd_data;

    assign en = ctrl_reg.sys_en;
    assign is_master = ctrl_reg.master;
    assign din = is_master ? pin_sync.miso : pin_sync.mosi;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ctrl_reg <= CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= bus_wdata;
            end
            if (mode_fault_flag_set) begin
                ctrl_reg.master <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            dir_reg <= DIR_RESET;
            port_reg <= PORT_RESET;
        end else begin
            if (wr_dir) begin
                dir_reg <= bus_wdata;
            end
            if (mode_fault_flag_set) begin
                dir_reg[SS_PIN:MISO_PIN] <= 4'h0;
            end
            if (wr_port) begin
                port_reg <= bus_wdata;
            end
        end
    end

    // ************************************************************
    // clock edges and rate divider
    // ************************************************************
    assign act_lvl = pin_sync.sck ^ ctrl_reg.cpol;
    assign shift_clk = ctrl_reg.cpha ? act_lvl
                     : (pin_sync.ss | act_lvl);
    assign rise = shift_clk && !clk_prev;
    assign fall = !shift_clk && clk_prev;
    assign ss_fall = !pin_sync.ss && ss_prev;
    assign ss_rise = pin_sync.ss && !ss_prev;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            clk_prev <= 1'b1;
            ss_prev <= 1'b1;
        end else begin
            clk_prev <= shift_clk;
            ss_prev <= pin_sync.ss;
        end
    end

    always_comb begin
        case (ctrl_reg.rate)
            2'b00: half_len = HALF_DIV2;
            2'b01: half_len = HALF_DIV4;
            2'b10: half_len = HALF_DIV16;
            default: half_len = HALF_DIV32;
        endcase
    end

    assign tick = en && is_master && (state_reg == XFER_RUN)
               && (div_cnt == 5'h01);

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            div_cnt <= 5'h00;
            half_idx <= 5'h00;
            msck_reg <= 1'b0;
        end else if (abort || load_ok) begin
            div_cnt <= half_len;
            half_idx <= 5'h00;
            msck_reg <= 1'b0;
        end else if (tick) begin
            div_cnt <= half_len;
            half_idx <= half_idx + 5'h01;
            msck_reg <= !msck_reg;
        end else if (state_reg == XFER_RUN) begin
            div_cnt <= div_cnt - 5'h01;
        end
    end

    // ************************************************************
    // shift events
    // ************************************************************
    always_comb begin
        sample_ev = 1'b0;
        drive_ev = 1'b0;
        if (!en) begin
            sample_ev = 1'b0;
        end else if (is_master) begin
            if (tick) begin
                sample_ev = (half_idx[0] == ctrl_reg.cpha);
                drive_ev = (half_idx[0] != ctrl_reg.cpha);
            end
        end else if (ctrl_reg.cpha) begin
            // select may stay low from byte to byte here
            drive_ev = rise && !pin_sync.ss;
            sample_ev = fall && !pin_sync.ss
                     && (state_reg == XFER_RUN);
        end else begin
            sample_ev = rise && (state_reg == XFER_RUN);
            drive_ev = fall && (state_reg == XFER_RUN);
        end
    end

    // ************************************************************
    // transfer control
    // ************************************************************
    assign busy = (state_reg != XFER_IDLE) || (en && !is_master
               && !ctrl_reg.cpha && !pin_sync.ss);
    assign load_ok = wr_data && !busy
                  && !(tc_reg && !tc_armed);
    assign mode_fault_flag_set = en && is_master && !pin_sync.ss
                   && !dir_reg[SS_PIN];
    assign abort = !en || mode_fault_flag_set;
    assign xfer_done = is_master
        ? (tick && (half_idx == LAST_HALF))
        : (sample_ev && (samp_cnt == LAST_SAMPLE));
    assign rx_value = sample_ev ? {shreg[6:0], din} : shreg;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_reg <= XFER_IDLE;
        end else if (abort) begin
            state_reg <= XFER_IDLE;
        end else begin
            case (state_reg)
                XFER_IDLE: begin
                    if (is_master && load_ok) begin
                        state_reg <= XFER_RUN;
                    end else if (!is_master && !ctrl_reg.cpha
                                 && ss_fall) begin
                        state_reg <= XFER_RUN;
                    end else if (!is_master && ctrl_reg.cpha
                                 && drive_ev) begin
                        state_reg <= XFER_RUN;
                    end
                end
                XFER_RUN: begin
                    if (!is_master && ss_rise) begin
                        state_reg <= XFER_IDLE;
                    end else if (xfer_done && !is_master
                                 && !ctrl_reg.cpha) begin
                        state_reg <= XFER_HOLD;
                    end else if (xfer_done) begin
                        state_reg <= XFER_IDLE;
                    end
                end
                XFER_HOLD: begin
                    if (ss_rise || is_master) begin
                        state_reg <= XFER_IDLE;
                    end
                end
                default: state_reg <= XFER_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            samp_cnt <= 4'h0;
        end else if (state_reg == XFER_IDLE) begin
            samp_cnt <= 4'h0;
        end else if (sample_ev) begin
            samp_cnt <= samp_cnt + 4'h1;
        end
    end

    // a collided write never reaches the shifter
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            shreg <= 8'h00;
            out_bit <= 1'b0;
        end else if (load_ok) begin
            shreg <= bus_wdata;
            out_bit <= bus_wdata[7];
        end else begin
            if (sample_ev) begin
                shreg <= {shreg[6:0], din};
            end
            if (drive_ev || (state_reg == XFER_IDLE && ss_fall)) begin
                out_bit <= shreg[7];
            end
        end
    end

    // an unread byte is kept and the new one is lost
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rx_buf <= 8'h00;
        end else if (xfer_done && !abort && (!tc_reg || tc_clr)) begin
            rx_buf <= rx_value;
        end
    end

    // ************************************************************
    // status flags, set beats clear
    // ************************************************************
    assign tc_set = xfer_done && !abort;
    assign tc_clr = tc_armed && data_acc;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tc_reg <= 1'b0;
            write_collision_flag_reg <= 1'b0;
            mode_fault_flag_reg <= 1'b0;
        end else begin
            tc_reg <= tc_set || (tc_reg && !tc_clr);
            write_collision_flag_reg <= (wr_data && busy)
                     || (write_collision_flag_reg && !(write_collision_flag_armed && data_acc));
            mode_fault_flag_reg <= mode_fault_flag_set
                     || (mode_fault_flag_reg && !(mode_fault_flag_armed && wr_ctrl));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            tc_armed <= 1'b0;
            write_collision_flag_armed <= 1'b0;
            mode_fault_flag_armed <= 1'b0;
        end else if (rd_flags) begin
            tc_armed <= tc_reg;
            write_collision_flag_armed <= write_collision_flag_reg;
            mode_fault_flag_armed <= mode_fault_flag_reg;
        end else begin
            if (data_acc) begin
                tc_armed <= 1'b0;
                write_collision_flag_armed <= 1'b0;
            end
            if (wr_ctrl) begin
                mode_fault_flag_armed <= 1'b0;
            end
        end
    end

    assign irq_request = ctrl_reg.int_en && (tc_reg || mode_fault_flag_reg)
                      && !cpu_int_mask;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            bus_rdata <= 8'h00;
        end else if (bus_read) begin
            case (bus_addr)
                DATA_OFFSET: bus_rdata <= rx_buf;
                CTRL_OFFSET: bus_rdata <= ctrl_reg;
                FLAGS_OFFSET: bus_rdata <= {tc_reg, write_collision_flag_reg, 1'b0,
                                 mode_fault_flag_reg, 4'h0};
                DIR_OFFSET: bus_rdata <= dir_reg;
                PORT_OFFSET: bus_rdata <= port_reg;
                default: bus_rdata <= 8'h00;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    // ************************************************************
    // pin multiplexing
    // ************************************************************
    always_comb begin
        drv_c = dir_reg[SS_PIN:MISO_PIN];
        val_c = port_reg[SS_PIN:MISO_PIN];
        if (en) begin
            drv_c.miso = !is_master && dir_reg[MISO_PIN]
                      && !pin_sync.ss;
            val_c.miso = out_bit;
            drv_c.mosi = is_master && dir_reg[MOSI_PIN];
            val_c.mosi = out_bit;
            drv_c.sck = is_master && dir_reg[SCK_PIN];
            val_c.sck = ctrl_reg.cpol ^ msck_reg;
            if (!(is_master && dir_reg[SS_PIN])) begin
                drv_c.ss = 1'b0;
            end
        end
    end

    // open drain only pulls low; high is left to the pull-up
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pin_out <= 4'h0;
            pin_oe <= 4'h0;
        end else if (ctrl_reg.open_drain) begin
            pin_out <= 4'h0;
            pin_oe <= drv_c & ~val_c;
        end else begin
            pin_out <= val_c;
            pin_oe <= drv_c;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_mode_fault_flag_sets: assert property (
        mode_fault_flag_set |=> mode_fault_flag_reg && !ctrl_reg.master)
        else $error("mode fault not flagged");
    chk_mode_fault_flag_masked: assert property (
        $rose(mode_fault_flag_reg) |-> !$past(dir_reg[SS_PIN]))
        else $error("mode fault despite output select");
    chk_mode_fault_flag_disarm: assert property (
        $rose(mode_fault_flag_reg) |-> dir_reg[SS_PIN:MISO_PIN] == 4'h0)
        else $error("directions kept after mode fault");
    chk_write_collision_flag_drop: assert property (
        (wr_data && busy && !sample_ev && !abort)
        |=> write_collision_flag_reg && shreg == $past(shreg))
        else $error("collided write reached shifter");
    chk_master_done: assert property (
        (tick && half_idx == LAST_HALF && !mode_fault_flag_set)
        |=> tc_reg && state_reg == XFER_IDLE)
        else $error("master end not flagged");
    chk_slave_hold: assert property (
        (xfer_done && !is_master && !ctrl_reg.cpha && !abort
         && !ss_rise) |=> state_reg == XFER_HOLD && tc_reg)
        else $error("slave byte end not held");
    chk_rate_div4: assert property (
        (tick && ctrl_reg.rate == 2'b01 && half_idx != LAST_HALF
         && !wr_ctrl && !mode_fault_flag_set) |=> !tick ##1 tick)
        else $error("divide by four broken");
    chk_sck_idle: assert property (
        (en && is_master && dir_reg[SCK_PIN] && !ctrl_reg.open_drain
         && state_reg == XFER_IDLE)
        |=> pin_out.sck == $past(ctrl_reg.cpol))
        else $error("clock not at rest level");
    chk_tc_clear: assert property (
        (tc_armed && rd_data && !tc_set) |=> !tc_reg)
        else $error("complete flag did not clear");
    chk_mode_fault_flag_clear: assert property (
        (mode_fault_flag_armed && wr_ctrl && !mode_fault_flag_set) |=> !mode_fault_flag_reg)
        else $error("mode fault did not clear");
    chk_irq_gate: assert property (
        irq_request |-> ctrl_reg.int_en && !cpu_int_mask)
        else $error("interrupt not gated");
    chk_overrun_keep: assert property (
        (xfer_done && tc_reg && !tc_clr) |=> rx_buf == $past(rx_buf))
        else $error("overrun overwrote buffer");
    chk_open_drain: assert property (
        ctrl_reg.open_drain |=> (pin_out & pin_oe) == 4'h0)
        else $error("open drain drove high");
    chk_flag_zeros: assert property (
        (bus_read && bus_addr == FLAGS_OFFSET)
        |=> bus_rdata[5] == 1'b0 && bus_rdata[3:0] == 4'h0)
        else $error("unused flag bits not zero");

    cov_master_byte: cover property (
        (is_master && load_ok) ##[1:600] tc_reg);
    cov_slave_cpha1: cover property (
        (!is_master && ctrl_reg.cpha && xfer_done));
    cov_collision: cover property ($rose(write_collision_flag_reg));
    cov_mode_fault: cover property ($rose(mode_fault_flag_reg));
endmodule : spi_master_slave_port
`default_nettype wire

/* test/spi_far_slave.sv */
// behavioural serial slave standing on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module spi_far_slave (
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_b,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic [7:0] rx_byte,
    output int n_bytes
);
    // ************************************************************
    // shifter
    // ************************************************************
    logic [7:0] sh = 8'h00;
    logic [7:0] acc = 8'h00;
    int cnt = 0;
    bit led = 0;
    wire ph = sck ^ cpol ^ cpha;
    // released line shows the inverse, never a held value
    assign miso = sel_b ? ~sh[7] : sh[7];
    initial n_bytes = 0;
    initial rx_byte = 8'h00;
    always @(negedge sel_b) begin
        sh = tx_byte;
        cnt = 0;
        led = 0;
    end
    always @(posedge ph) if (!sel_b) begin
        acc = {acc[6:0], mosi};
        cnt++;
        if (cnt == 8) begin
            rx_byte = acc;
            n_bytes++;
            cnt = 0;
            led = 0;
            sh = tx_byte; // select may stay low in phase one
        end
    end
    // phase one: first leading edge presents bit 7, no shift
    always @(negedge ph) if (!sel_b) begin
        if (cpha && !led) led = 1;
        else sh = {sh[6:0], 1'b0};
    end
endmodule : spi_far_slave
`default_nettype wire

/* test/tb_spi_master_slave_port.sv */
// self-checking bench for the serial port, master and slave side traffic
`timescale 1ns/1ps
`default_nettype none
module tb_spi_master_slave_port;
    import spi_port_pkg::*;
    logic ref_clk, rst_b, bus_write, bus_read, cpu_int_mask, irq_request;
    logic [15:0] bus_addr;
    logic [7:0] bus_wdata, bus_rdata, f, tx_far, rx_far;
    logic ss_drv_b, sel_b, cpol, cpha, far_miso, sck_q, sck_drv, mosi_drv;
    pins_t pin_in, pin_out, pin_oe;
    int n_fail = 0;
    int num_checks = 0;
    int nb, nb0, run, half_meas;
    int half_exp [4] = '{2/2, 4/2, 16/2, 32/2};
    // ************************************************************
    // wire levels and instances
    // ************************************************************
    assign pin_in.ss = pin_oe.ss ? pin_out.ss : ss_drv_b;
    // undriven clock and mosi lines belong to the bench's own master, undriven miso to the far slave
    assign pin_in.sck = pin_oe.sck ? pin_out.sck : sck_drv;
    assign pin_in.mosi = pin_oe.mosi ? pin_out.mosi : mosi_drv;
    assign pin_in.miso = pin_oe.miso ? pin_out.miso : far_miso;
    spi_master_slave_port i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write), .bus_read(bus_read),
        .bus_rdata(bus_rdata), .cpu_int_mask(cpu_int_mask),
        .irq_request(irq_request), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));
    spi_far_slave i_far (.sck(pin_in.sck), .mosi(pin_in.mosi),
        .sel_b(sel_b), .cpol(cpol), .cpha(cpha), .tx_byte(tx_far),
        .miso(far_miso), .rx_byte(rx_far), .n_bytes(nb));
    // last serial clock half period, in bus cycles
    always @(posedge ref_clk) begin
        if (pin_out.sck !== sck_q) begin
            half_meas <= run;
            run <= 1;
        end else run <= run + 1;
        sck_q <= pin_out.sck;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge ref_clk);
        bus_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge ref_clk);
        bus_read <= 1'b0;
        #1 d = bus_rdata;
    endtask : rd
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(d, e);
    endtask : rdc
    // polling arms the set flags, as software would
    task automatic wait_tc(output logic [7:0] v);
        for (int k = 0; k < 400; k++) begin
            rd(FLAGS_OFFSET, v);
            if (v[TC_BIT] === 1'b1) return;
        end
        n_fail++;
        end_sim();
    endtask : wait_tc
    // external master for the slave test, phase one, polarity zero
    task automatic ext_byte(input logic [7:0] d, output logic [7:0] q);
        for (int b = 7; b >= 0; b--) begin
            @(posedge ref_clk);
            sck_drv <= 1'b1;
            mosi_drv <= d[b];
            repeat (6) @(posedge ref_clk);
            q[b] = pin_in.miso;
            sck_drv <= 1'b0;
            repeat (5) @(posedge ref_clk);
        end
    endtask : ext_byte
    // ************************************************************
    // clock and sequence
    // ************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        {rst_b, bus_write, bus_read, cpu_int_mask} = 4'h0;
        {bus_addr, bus_wdata} = 24'h000000;
        {ss_drv_b, sel_b, cpol, cpha, tx_far} = 12'hc00;
        {sck_drv, mosi_drv} = 2'b00;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        rdc(CTRL_OFFSET, CTRL_RESET);
        rdc(FLAGS_OFFSET, 8'h00);
        rdc(16'h1030, 8'h00);
        $display("test reset done");
        wr(DIR_OFFSET, 8'h38); // select pin driven low as output
        for (int i = 0; i < 4; i++) begin
            cpol = i[0];
            cpha = i[1];
            tx_far = 8'h5a ^ i[7:0];
            wr(CTRL_OFFSET, {4'h5, i[0], i[1], i[1:0]});
            // clock must reach its new rest level before select falls
            repeat (2) @(posedge ref_clk);
            chk(pin_oe, 4'he);
            sel_b <= 1'b0;
            wr(DATA_OFFSET, 8'ha5 + i[7:0]);
            wait_tc(f);
            chk(f, 8'h80);
            sel_b <= 1'b1;
            chk(half_meas, half_exp[i]);
            chk(pin_out.sck, i[0]);
            chk(rx_far, 8'ha5 + i[7:0]);
            if (i > 1) rdc(DATA_OFFSET, 8'h5a ^ i[7:0]);
            else rd(DATA_OFFSET, f);
            rdc(FLAGS_OFFSET, 8'h00);
        end
        $display("test rates done");
        cpol = 1'b0;
        wr(CTRL_OFFSET, 8'h56);
        repeat (2) @(posedge ref_clk);
        sel_b <= 1'b0;
        wr(DATA_OFFSET, 8'h11);
        wr(DATA_OFFSET, 8'h22);
        wait_tc(f);
        chk(f, 8'hc0);
        chk(rx_far, 8'h11);
        rdc(DATA_OFFSET, 8'h59);
        rdc(FLAGS_OFFSET, 8'h00);
        nb0 = nb;
        wr(DATA_OFFSET, 8'h44);
        for (int k = 0; k < 400 && nb == nb0; k++) @(posedge ref_clk);
        if (nb == nb0) begin
            n_fail++;
            end_sim();
        end
        chk(rx_far, 8'h44);
        repeat (4) @(posedge ref_clk);
        wr(DATA_OFFSET, 8'h55);
        repeat (200) @(posedge ref_clk);
        chk(nb, nb0 + 1);
        rdc(FLAGS_OFFSET, 8'h80);
        rdc(DATA_OFFSET, 8'h59);
        sel_b <= 1'b1;
        $display("test collision done");
        // select pin goes high and settles before it stops being an output
        wr(PORT_OFFSET, 8'h20);
        @(posedge ref_clk);
        wr(DIR_OFFSET, 8'h18);
        wr(CTRL_OFFSET, 8'hd0);
        ss_drv_b <= 1'b0;
        repeat (4) @(posedge ref_clk);
        ss_drv_b <= 1'b1;
        chk(irq_request, 1'b1);
        rdc(CTRL_OFFSET, 8'hc0);
        rdc(DIR_OFFSET, 8'h00);
        cpu_int_mask <= 1'b1;
        @(posedge ref_clk);
        #1 chk(irq_request, 1'b0);
        rdc(FLAGS_OFFSET, 8'h10);
        wr(CTRL_OFFSET, 8'h00);
        rdc(FLAGS_OFFSET, 8'h00);
        $display("test mode fault done");
        wr(DIR_OFFSET, 8'h04);
        wr(CTRL_OFFSET, 8'h44);
        wr(DATA_OFFSET, 8'h3c);
        chk(pin_oe, 4'h0);
        ss_drv_b <= 1'b0;
        ext_byte(8'hc3, f);
        ss_drv_b <= 1'b1;
        chk(f, 8'h3c);
        rdc(FLAGS_OFFSET, 8'h80);
        rdc(DATA_OFFSET, 8'hc3);
        wr(CTRL_OFFSET, 8'h20);
        repeat (2) @(posedge ref_clk);
        chk({pin_out, pin_oe}, 8'h01);
        $display("test slave done");
        end_sim();
    end
endmodule : tb_spi_master_slave_port
`default_nettype wire
